// File: rtl/pcr_cfg_map.vh
`ifndef PCR_CFG_MAP_VH
`define PCR_CFG_MAP_VH
// local addresses of the four registers and the command status field
`define PCR_ADDR_CMD_STATUS 4'h0
`define PCR_ADDR_BAR5_MASK 4'h1
`define PCR_ADDR_STICKY 4'h2
`define PCR_ADDR_NONSTICKY 4'h3
`define PCR_MASK_ACCESS_BIT 5
// reset values
`define PCR_RST_CMD_STATUS 32'h0000_0000
`define PCR_RST_BAR5_MASK 32'h0000_0000
`define PCR_RST_STICKY 32'h0000_0000
`define PCR_RST_NONSTICKY 32'h0000_0000
`endif

// File: rtl/pcr_cfg_reset_access.v
`timescale 1ns/1ps
`include "pcr_cfg_map.vh"

module pcr_cfg_reset_access (
   // clock and hard reset
   input wire CLK,
   input wire RST_N,
   // reset requests, one-cycle pulses
   input wire HOT_RST,
   input wire SOFT_RST,
   // local write port
   input wire LCL_WR,
   input wire [3:0] LCL_ADDR,
   input wire [31:0] LCL_WDATA,
   // link-side write attempt to the mask
   input wire LINK_MASK_WR,
   input wire [31:0] LINK_MASK_WDATA,
   // read data of the local port
   output wire [31:0] LCL_RDATA,
   // window five state
   output wire [31:0] BAR5_MASK,
   output wire BAR5_ENABLED,
   // command status enable bit
   output wire MASK_ACCESS_ENABLE,
   // sticky and non-sticky registers
   output wire [31:0] STICKY_BITS,
   output wire [31:0] NONSTICKY_BITS
);

   // notes for users of this block:
   // - the mask location stays locked until the enable bit is set
   // - a reset request and a local write in one cycle: the reset wins
   // - the link side has no write path into the mask at all
   // - hot and soft resets are not told apart here
   // - read data lags the address by one clock

   // reset images of the registers
   wire [31:0] rst_cmd_word;
   wire [31:0] rst_mask_word;
   wire [31:0] rst_sticky_word;
   wire [31:0] rst_nonsticky_word;

   // decoded requests
   wire rst_req;
   wire sel_cmd;
   wire sel_mask;
   wire sel_sticky;
   wire sel_nonsticky;
   wire wr_cmd;
   wire wr_mask;
   wire wr_sticky;
   wire wr_nonsticky;

   // register state and next values
   reg mask_access_ff;
   reg nxt_mask_access;
   reg [31:0] bar5_mask_ff;
   reg [31:0] nxt_bar5_mask;
   reg bar5_enabled_ff;
   reg nxt_bar5_enabled;
   reg [31:0] sticky_ff;
   reg [31:0] nxt_sticky;
   reg [31:0] nonsticky_ff;
   reg [31:0] nxt_nonsticky;
   reg [31:0] rdata_ff;
   reg [31:0] nxt_rdata;

   // reset values kept as words so single bits can be picked out
   assign rst_cmd_word = `PCR_RST_CMD_STATUS;
   assign rst_mask_word = `PCR_RST_BAR5_MASK;
   assign rst_sticky_word = `PCR_RST_STICKY;
   assign rst_nonsticky_word = `PCR_RST_NONSTICKY;

   // hot and soft reset act alike on this block
   assign rst_req = HOT_RST | SOFT_RST;

   // address decode of the local port
   assign sel_cmd = (LCL_ADDR == `PCR_ADDR_CMD_STATUS);
   assign sel_mask = (LCL_ADDR == `PCR_ADDR_BAR5_MASK);
   assign sel_sticky = (LCL_ADDR == `PCR_ADDR_STICKY);
   assign sel_nonsticky = (LCL_ADDR == `PCR_ADDR_NONSTICKY);

   // command status write; a reset request in the same cycle wins
   assign wr_cmd = LCL_WR & sel_cmd & ~rst_req;
   // mask only writable locally while unlocked
   assign wr_mask = LCL_WR & sel_mask & mask_access_ff & ~rst_req;
   // sticky writes held off during a reset request so the word survives it
   assign wr_sticky = LCL_WR & sel_sticky & ~rst_req;
   // non-sticky write
   assign wr_nonsticky = LCL_WR & sel_nonsticky & ~rst_req;

   // link-side mask writes are deliberately not decoded:
   // the link strobe and data have no path into the mask

   // next value of the mask-access enable bit
   always @* begin
      nxt_mask_access = mask_access_ff;
      if (rst_req) begin
         nxt_mask_access = rst_cmd_word[`PCR_MASK_ACCESS_BIT];
      end else if (wr_cmd) begin
         nxt_mask_access = LCL_WDATA[`PCR_MASK_ACCESS_BIT];
      end
   end

   // enable bit flip-flop
   always @(posedge CLK) begin
      if (!RST_N) begin
         mask_access_ff <= rst_cmd_word[`PCR_MASK_ACCESS_BIT];
      end else begin
         mask_access_ff <= nxt_mask_access;
      end
   end

   // next value of the window five mask, left unprogrammed at boot
   always @* begin
      nxt_bar5_mask = bar5_mask_ff;
      nxt_bar5_enabled = bar5_enabled_ff;
      if (rst_req) begin
         nxt_bar5_mask = rst_mask_word;
         nxt_bar5_enabled = 1'b0;
      end else if (wr_mask) begin
         nxt_bar5_mask = LCL_WDATA;
         nxt_bar5_enabled = LCL_WDATA[0]; // window opens only when bit 0 of the written mask is set
      end
   end

   // window five flip-flops
   always @(posedge CLK) begin
      if (!RST_N) begin
         bar5_mask_ff <= rst_mask_word;
         bar5_enabled_ff <= 1'b0;
      end else begin
         bar5_mask_ff <= nxt_bar5_mask;
         bar5_enabled_ff <= nxt_bar5_enabled;
      end
   end

   // next value of the sticky register; hot and soft resets leave it alone
   always @* begin
      nxt_sticky = sticky_ff;
      if (wr_sticky) begin
         nxt_sticky = LCL_WDATA;
      end
   end

   // sticky flip-flops, cleared by the hard reset only
   always @(posedge CLK) begin
      if (!RST_N) begin
         sticky_ff <= rst_sticky_word;
      end else begin
         sticky_ff <= nxt_sticky;
      end
   end

   // next value of the non-sticky register
   always @* begin
      nxt_nonsticky = nonsticky_ff;
      if (rst_req) begin
         nxt_nonsticky = rst_nonsticky_word;
      end else if (wr_nonsticky) begin
         nxt_nonsticky = LCL_WDATA;
      end
   end

   // non-sticky flip-flops
   always @(posedge CLK) begin
      if (!RST_N) begin
         nonsticky_ff <= rst_nonsticky_word;
      end else begin
         nonsticky_ff <= nxt_nonsticky;
      end
   end

   // read mux over the four local locations
   always @* begin
      nxt_rdata = 32'h0000_0000;
      case (LCL_ADDR)
         `PCR_ADDR_CMD_STATUS: begin
            nxt_rdata[`PCR_MASK_ACCESS_BIT] = mask_access_ff;
         end
         `PCR_ADDR_BAR5_MASK: begin
            nxt_rdata = bar5_mask_ff;
         end
         `PCR_ADDR_STICKY: begin
            nxt_rdata = sticky_ff;
         end
         `PCR_ADDR_NONSTICKY: begin
            nxt_rdata = nonsticky_ff;
         end
         default: begin
            nxt_rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data register, one cycle behind the address
   always @(posedge CLK) begin
      if (!RST_N) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // read data output
   assign LCL_RDATA = rdata_ff;
   // window five outputs
   assign BAR5_MASK = bar5_mask_ff;
   assign BAR5_ENABLED = bar5_enabled_ff;
   // enable bit output
   assign MASK_ACCESS_ENABLE = mask_access_ff;
   // sticky and non-sticky outputs
   assign STICKY_BITS = sticky_ff;
   assign NONSTICKY_BITS = nonsticky_ff;

endmodule // pcr_cfg_reset_access

// File: verif/pcr_chk_assertions.sv
`timescale 1ns/1ps
module pcr_chk (
   // clock and resets
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic HOT_RST,
   input wire logic SOFT_RST,
   // local write port
   input wire logic LCL_WR,
   input wire logic [3:0] LCL_ADDR,
   input wire logic [31:0] LCL_WDATA,
   // register state
   input wire logic MASK_ACCESS_ENABLE,
   input wire logic BAR5_ENABLED,
   input wire logic [31:0] BAR5_MASK,
   input wire logic [31:0] STICKY_BITS,
   input wire logic [31:0] NONSTICKY_BITS
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire rst_req = HOT_RST | SOFT_RST;
   wire wr_ok = LCL_WR & !rst_req;
   property p_hrd;
      $rose(RST_N) |-> (BAR5_MASK | STICKY_BITS | NONSTICKY_BITS) == 32'h0000_0000
         && !BAR5_ENABLED && !MASK_ACCESS_ENABLE;
   endproperty
   a_hrd: assert property (p_hrd) else $error("state not clear");
   property p_en;
      wr_ok && LCL_ADDR == 4'h0 |=> MASK_ACCESS_ENABLE == $past(LCL_WDATA[5]);
   endproperty
   a_en: assert property (p_en) else $error("enable wrong");
   property p_msk;
      wr_ok && LCL_ADDR == 4'h1 && MASK_ACCESS_ENABLE |=> BAR5_MASK == $past(LCL_WDATA);
   endproperty
   a_msk: assert property (p_msk) else $error("mask not taken");
   property p_lck;
      !MASK_ACCESS_ENABLE && !rst_req |=> $stable(BAR5_MASK);
   endproperty
   a_lck: assert property (p_lck) else $error("locked mask moved");
   property p_hot;
      HOT_RST |=> $stable(STICKY_BITS) && NONSTICKY_BITS == 32'h0000_0000;
   endproperty
   a_hot: assert property (p_hot) else $error("hot reset wrong");
   property p_sft;
      SOFT_RST |=> $stable(STICKY_BITS) && NONSTICKY_BITS == 32'h0000_0000;
   endproperty
   a_sft: assert property (p_sft) else $error("soft reset wrong");
endmodule // pcr_chk
bind pcr_cfg_reset_access pcr_chk i_pcr_chk (
   .CLK(CLK),
   .RST_N(RST_N),
   .HOT_RST(HOT_RST),
   .SOFT_RST(SOFT_RST),
   .LCL_WR(LCL_WR),
   .LCL_ADDR(LCL_ADDR),
   .LCL_WDATA(LCL_WDATA),
   .MASK_ACCESS_ENABLE(MASK_ACCESS_ENABLE),
   .BAR5_ENABLED(BAR5_ENABLED),
   .BAR5_MASK(BAR5_MASK),
   .STICKY_BITS(STICKY_BITS),
   .NONSTICKY_BITS(NONSTICKY_BITS)
);

// File: verif/pcr_link_model.sv
`timescale 1ns/1ps
module pcr_link_model (
   input wire logic go,
   output logic wr,
   output logic [31:0] d
);
   // root complex leaves the mask alone unless told to misbehave
   assign wr = go;
   assign d = go ? 32'hFFFF_FFFF : 32'h0000_0000;
endmodule // pcr_link_model

// File: verif/tb_pcie_ep_config_reset_access.sv
`timescale 1ns/1ps
`define CHK(a,b) begin n_compared++; if ((a)!==(b)) begin n_mismatch++; \
 $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_pcie_ep_config_reset_access;
   logic CLK=0, RST_N=0, HOT_RST=0, SOFT_RST=0, LCL_WR=0, go=0;
   logic [3:0] LCL_ADDR=0;
   logic [31:0] LCL_WDATA=0, LINK_MASK_WDATA, LCL_RDATA, BAR5_MASK, STICKY_BITS, NONSTICKY_BITS;
   logic LINK_MASK_WR, BAR5_ENABLED, MASK_ACCESS_ENABLE;
   int n_mismatch=0, n_compared=0;
   always #2.5 CLK = ~CLK;
   pcr_cfg_reset_access i_pcr_cfg_reset_access (
      .CLK(CLK),
      .RST_N(RST_N),
      .HOT_RST(HOT_RST),
      .SOFT_RST(SOFT_RST),
      .LCL_WR(LCL_WR),
      .LCL_ADDR(LCL_ADDR),
      .LCL_WDATA(LCL_WDATA),
      .LINK_MASK_WR(LINK_MASK_WR),
      .LINK_MASK_WDATA(LINK_MASK_WDATA),
      .LCL_RDATA(LCL_RDATA),
      .BAR5_MASK(BAR5_MASK),
      .BAR5_ENABLED(BAR5_ENABLED),
      .MASK_ACCESS_ENABLE(MASK_ACCESS_ENABLE),
      .STICKY_BITS(STICKY_BITS),
      .NONSTICKY_BITS(NONSTICKY_BITS)
   );
   pcr_link_model i_pcr_link_model (.go(go), .wr(LINK_MASK_WR), .d(LINK_MASK_WDATA));
   task wr(input [3:0] a, input [31:0] d);
      @(negedge CLK) {LCL_WR,LCL_ADDR,LCL_WDATA} = {1'b1,a,d};
      @(negedge CLK) LCL_WR = 0;
   endtask
   task pulse(input h);
      @(negedge CLK) {HOT_RST,SOFT_RST} = {h,!h};
      @(negedge CLK) {HOT_RST,SOFT_RST} = 2'b00;
   endtask
   task t_lock;
      `CHK(BAR5_ENABLED, 1'b0)
      go = 1;
      wr(4'h1, 32'hFFF0_0001);
      go = 0;
      `CHK(BAR5_MASK, 32'h0000_0000)
      `CHK(BAR5_ENABLED, 1'b0)
      $display("lock done");
   endtask
   task t_prog;
      wr(4'h0, 32'h0000_0020);
      `CHK(MASK_ACCESS_ENABLE, 1'b1)
      @(negedge CLK);
      `CHK(LCL_RDATA, 32'h0000_0020)
      wr(4'h1, 32'hFFF0_0001);
      `CHK(BAR5_MASK, 32'hFFF0_0001)
      `CHK(BAR5_ENABLED, 1'b1)
      @(negedge CLK);
      `CHK(LCL_RDATA, 32'hFFF0_0001)
      wr(4'h0, 32'h0000_0000);
      `CHK(MASK_ACCESS_ENABLE, 1'b0)
      $display("prog done");
   endtask
   task t_rst;
      wr(4'h2, 32'hA5A5_0001);
      @(negedge CLK);
      `CHK(LCL_RDATA, 32'hA5A5_0001)
      wr(4'h3, 32'h5A5A_0002);
      pulse(1'b1);
      `CHK(STICKY_BITS, 32'hA5A5_0001)
      `CHK(NONSTICKY_BITS, 32'h0000_0000)
      wr(4'h3, 32'h0000_0003);
      pulse(1'b0);
      `CHK(STICKY_BITS, 32'hA5A5_0001)
      `CHK(NONSTICKY_BITS, 32'h0000_0000)
      RST_N = 0;
      repeat (2) @(negedge CLK);
      `CHK(STICKY_BITS, 32'h0000_0000)
      `CHK(BAR5_MASK, 32'h0000_0000)
      RST_N = 1;
      wr(4'h2, 32'h0000_0004);
      `CHK(STICKY_BITS, 32'h0000_0004)
      $display("reset done");
   endtask
   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge CLK);
      RST_N = 1;
      t_lock;
      t_prog;
      t_rst;
      end_sim;
   end
endmodule // tb_pcie_ep_config_reset_access
